/* src/pmsr_status_regs.sv */
// Status register bank of the hot-swap power monitor, read by command code
`timescale 1ns/1ps
`include "pmsr_consts.svh"

module pmsr_status_regs
    import pmsr_pkg::*;
#(
    parameter bit HAS_OUTPUT_VOLTAGE_SENSE_PIN_SENSE = 1'b1
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic cmd_valid_in,
    input wire logic [`PMSR_BYTE_W-1:0] cmd_code_in,
    input wire logic clear_faults_in,
    input wire pmsr_mon_events_s mon_events_in,
    input wire logic gate_off_in,
    input wire logic [`PMSR_BYTE_W-1:0] maker_specific_flags_in,
    input wire logic feedback_sense_pin_in,
    input wire logic input_high_threshold_pin_in,
    input wire logic input_low_threshold_pin_in,
    output pmsr_reply_s reply_out,
    output logic power_ok_pin_out
);

    // Comparator pins are asynchronous to the register clock
    logic fb_above;
    logic hi_above;
    logic lo_above;

    pmsr_sync2 #(
        .WIDTH(1),
        .RESET_VAL(`PMSR_FB_SYNC_RST)
    ) u_sync_fb (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(feedback_sense_pin_in),
        .sync_out(fb_above)
    );

    pmsr_sync2 #(
        .WIDTH(1),
        .RESET_VAL(`PMSR_HI_SYNC_RST)
    ) u_sync_hi (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(input_high_threshold_pin_in),
        .sync_out(hi_above)
    );

    pmsr_sync2 #(
        .WIDTH(1),
        .RESET_VAL(`PMSR_LO_SYNC_RST)
    ) u_sync_lo (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(input_low_threshold_pin_in),
        .sync_out(lo_above)
    );

    // Power-ok pin follows the synchronised feedback comparator
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            power_ok_pin_out <= `PMSR_FB_SYNC_RST;
        end else begin
            power_ok_pin_out <= fb_above;
        end
    end

    // Set vectors for each latched register
    logic [`PMSR_BYTE_W-1:0] output_voltage_sense_pin_set;
    logic [`PMSR_BYTE_W-1:0] iout_set;
    logic [`PMSR_BYTE_W-1:0] input_set;
    logic comm_err_set;

    always_comb begin
        output_voltage_sense_pin_set = `PMSR_BYTE_RST;
        if (HAS_OUTPUT_VOLTAGE_SENSE_PIN_SENSE) begin
            output_voltage_sense_pin_set[`PMSR_OV_HIGH_WARN_BIT] = mon_events_in.output_high_warning;
            output_voltage_sense_pin_set[`PMSR_OV_LOW_WARN_BIT] = mon_events_in.output_low_warning;
        end
    end

    always_comb begin
        iout_set = `PMSR_BYTE_RST;
        iout_set[`PMSR_OC_TIMEOUT_BIT] = mon_events_in.current_timeout_fault;
        iout_set[`PMSR_OC_HIGH_WARN_BIT] = mon_events_in.current_high_warning;
    end

    always_comb begin
        input_set = `PMSR_BYTE_RST;
        input_set[`PMSR_IN_HIGH_PIN_BIT] = hi_above;
        input_set[`PMSR_IN_HIGH_WARN_BIT] = mon_events_in.input_high_warning;
        input_set[`PMSR_IN_LOW_WARN_BIT] = mon_events_in.input_low_warning;
        input_set[`PMSR_IN_LOW_PIN_BIT] = ~lo_above;
    end

    // Any unsupported command code is a communication error
    logic cmd_known;

    always_comb begin
        unique case (cmd_code_in)
            `PMSR_CMD_STATUS_BYTE: cmd_known = 1'b1;
            `PMSR_CMD_SUMMARY: cmd_known = 1'b1;
            `PMSR_CMD_OUTPUT_VOLTAGE_SENSE_PIN_FLAGS: cmd_known = HAS_OUTPUT_VOLTAGE_SENSE_PIN_SENSE;
            `PMSR_CMD_IOUT_FLAGS: cmd_known = 1'b1;
            `PMSR_CMD_INPUT_FLAGS: cmd_known = 1'b1;
            default: cmd_known = 1'b0;
        endcase
    end

    assign comm_err_set = cmd_valid_in & ~cmd_known;

    logic [`PMSR_BYTE_W-1:0] output_voltage_flags_q;
    logic [`PMSR_BYTE_W-1:0] output_current_flags_q;
    logic [`PMSR_BYTE_W-1:0] input_supply_flags_q;
    logic comm_err_q;

    pmsr_sticky_flags #(
        .WIDTH(`PMSR_BYTE_W)
    ) u_output_voltage_sense_pin_flags (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .set_in(output_voltage_sense_pin_set),
        .clear_in(clear_faults_in),
        .flags_out(output_voltage_flags_q)
    );

    pmsr_sticky_flags #(
        .WIDTH(`PMSR_BYTE_W)
    ) u_iout_flags (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .set_in(iout_set),
        .clear_in(clear_faults_in),
        .flags_out(output_current_flags_q)
    );

    pmsr_sticky_flags #(
        .WIDTH(`PMSR_BYTE_W)
    ) u_input_flags (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .set_in(input_set),
        .clear_in(clear_faults_in),
        .flags_out(input_supply_flags_q)
    );

    pmsr_sticky_flags #(
        .WIDTH(1)
    ) u_comm_err (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .set_in(comm_err_set),
        .clear_in(clear_faults_in),
        .flags_out(comm_err_q)
    );

    // Read views; reserved positions are never set, masks keep them zero
    logic [`PMSR_BYTE_W-1:0] output_voltage_flags;
    logic [`PMSR_BYTE_W-1:0] output_current_flags;
    logic [`PMSR_BYTE_W-1:0] input_supply_flags;

    always_comb begin
        output_voltage_flags = `PMSR_BYTE_RST;
        output_current_flags = `PMSR_BYTE_RST;
        output_voltage_flags[`PMSR_OV_HIGH_WARN_BIT] =
            output_voltage_flags_q[`PMSR_OV_HIGH_WARN_BIT];
        output_voltage_flags[`PMSR_OV_LOW_WARN_BIT] =
            output_voltage_flags_q[`PMSR_OV_LOW_WARN_BIT];
        output_current_flags[`PMSR_OC_TIMEOUT_BIT] =
            output_current_flags_q[`PMSR_OC_TIMEOUT_BIT];
        output_current_flags[`PMSR_OC_HIGH_WARN_BIT] =
            output_current_flags_q[`PMSR_OC_HIGH_WARN_BIT];
    end

    always_comb begin
        input_supply_flags = `PMSR_BYTE_RST;
        input_supply_flags[`PMSR_IN_HIGH_PIN_BIT] =
            input_supply_flags_q[`PMSR_IN_HIGH_PIN_BIT];
        input_supply_flags[`PMSR_IN_HIGH_WARN_BIT] =
            input_supply_flags_q[`PMSR_IN_HIGH_WARN_BIT];
        input_supply_flags[`PMSR_IN_LOW_WARN_BIT] =
            input_supply_flags_q[`PMSR_IN_LOW_WARN_BIT];
        input_supply_flags[`PMSR_IN_LOW_PIN_BIT] =
            input_supply_flags_q[`PMSR_IN_LOW_PIN_BIT];
    end

    // Live pending summaries
    logic output_voltage_pending;
    logic output_current_pending;
    logic input_supply_pending;
    logic maker_flags_pending;
    logic other_flags_pending;

    assign output_voltage_pending = |output_voltage_flags;
    assign output_current_pending = |output_current_flags;
    assign input_supply_pending = |input_supply_flags;
    assign maker_flags_pending = |maker_specific_flags_in;
    assign other_flags_pending = output_voltage_pending | output_current_pending
        | input_supply_pending | maker_flags_pending;

    logic [`PMSR_BYTE_W-1:0] status_byte;
    logic [`PMSR_WORD_W-1:0] summary_status;

    always_comb begin
        status_byte = `PMSR_BYTE_RST;
        status_byte[`PMSR_SB_GATE_OFF_BIT] = gate_off_in;
        status_byte[`PMSR_SB_CUR_FAULT_BIT] = output_current_flags[`PMSR_OC_TIMEOUT_BIT];
        status_byte[`PMSR_SB_LOW_PIN_BIT] = input_supply_flags[`PMSR_IN_LOW_PIN_BIT];
        status_byte[`PMSR_SB_COMM_ERR_BIT] = comm_err_q;
        status_byte[`PMSR_SB_OTHER_BIT] = other_flags_pending;
    end

    always_comb begin
        summary_status = `PMSR_SUMMARY_RST;
        summary_status[`PMSR_SW_OUTPUT_VOLTAGE_SENSE_PIN_BIT] = output_voltage_pending;
        summary_status[`PMSR_SW_IOUT_BIT] = output_current_pending;
        summary_status[`PMSR_SW_INPUT_BIT] = input_supply_pending;
        summary_status[`PMSR_SW_MAKER_BIT] = maker_flags_pending;
        summary_status[`PMSR_SW_PGOOD_N_BIT] = ~power_ok_pin_out;
        summary_status[`PMSR_SW_RSVD_HI:`PMSR_SW_RSVD_LO] = `PMSR_SW_RSVD_ZERO;
        summary_status[`PMSR_SW_BYTE_HI:0] = status_byte;
    end

    // Answer selection; every field comes from one cycle's values
    pmsr_reply_s next_reply;

    always_comb begin
        next_reply = '0;
        next_reply.valid = cmd_valid_in;
        if (cmd_valid_in) begin
            unique case (cmd_code_in)
                `PMSR_CMD_STATUS_BYTE: begin
                    next_reply.data = {{`PMSR_BYTE_W{1'b0}}, status_byte};
                end
                `PMSR_CMD_SUMMARY: begin
                    next_reply.is_word = 1'b1;
                    next_reply.data = summary_status;
                end
                `PMSR_CMD_OUTPUT_VOLTAGE_SENSE_PIN_FLAGS: begin
                    next_reply.refused = ~HAS_OUTPUT_VOLTAGE_SENSE_PIN_SENSE;
                    next_reply.data = {{`PMSR_BYTE_W{1'b0}}, output_voltage_flags};
                end
                `PMSR_CMD_IOUT_FLAGS: begin
                    next_reply.data = {{`PMSR_BYTE_W{1'b0}}, output_current_flags};
                end
                `PMSR_CMD_INPUT_FLAGS: begin
                    next_reply.data = {{`PMSR_BYTE_W{1'b0}}, input_supply_flags};
                end
                default: begin
                    next_reply.refused = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            reply_out <= '0;
        end else begin
            reply_out <= next_reply;
        end
    end

endmodule : pmsr_status_regs

/* src/pmsr_consts.svh */
// Constants for the power monitor status register bank
`ifndef PMSR_CONSTS_SVH
`define PMSR_CONSTS_SVH

`define PMSR_WORD_W 16
`define PMSR_BYTE_W 8

// Command codes
`define PMSR_CMD_STATUS_BYTE 8'h78
`define PMSR_CMD_SUMMARY 8'h79
`define PMSR_CMD_OUTPUT_VOLTAGE_SENSE_PIN_FLAGS 8'h7A
`define PMSR_CMD_IOUT_FLAGS 8'h7B
`define PMSR_CMD_INPUT_FLAGS 8'h7C

// Reset values
`define PMSR_SUMMARY_RST 16'h0000
`define PMSR_BYTE_RST 8'h00

// Summary word fields
`define PMSR_SW_OUTPUT_VOLTAGE_SENSE_PIN_BIT 15
`define PMSR_SW_IOUT_BIT 14
`define PMSR_SW_INPUT_BIT 13
`define PMSR_SW_MAKER_BIT 12
`define PMSR_SW_PGOOD_N_BIT 11
`define PMSR_SW_RSVD_HI 10
`define PMSR_SW_RSVD_LO 8
`define PMSR_SW_RSVD_ZERO 3'h0
`define PMSR_SW_BYTE_HI 7

// Single-byte status fields
`define PMSR_SB_GATE_OFF_BIT 6
`define PMSR_SB_CUR_FAULT_BIT 4
`define PMSR_SB_LOW_PIN_BIT 3
`define PMSR_SB_COMM_ERR_BIT 1
`define PMSR_SB_OTHER_BIT 0

// Output-voltage flag fields
`define PMSR_OV_HIGH_WARN_BIT 6
`define PMSR_OV_LOW_WARN_BIT 5

// Output-current flag fields
`define PMSR_OC_TIMEOUT_BIT 7
`define PMSR_OC_HIGH_WARN_BIT 5

// Input-supply flag fields
`define PMSR_IN_HIGH_PIN_BIT 7
`define PMSR_IN_HIGH_WARN_BIT 6
`define PMSR_IN_LOW_WARN_BIT 5
`define PMSR_IN_LOW_PIN_BIT 4

// Synchroniser reset levels: comparators idle at "good"
`define PMSR_FB_SYNC_RST 1'h1
`define PMSR_HI_SYNC_RST 1'h0
`define PMSR_LO_SYNC_RST 1'h1

`endif

/* src/pmsr_pkg.sv */
// Types shared by the power monitor status register bank
`include "pmsr_consts.svh"

package pmsr_pkg;

    // Same-clock event pulses or levels from the monitor and fault timer
    typedef struct packed {
        logic output_high_warning;
        logic output_low_warning;
        logic current_timeout_fault;
        logic current_high_warning;
        logic input_high_warning;
        logic input_low_warning;
    } pmsr_mon_events_s;

    // One status read answer
    typedef struct packed {
        logic valid;
        logic is_word;
        logic refused;
        logic [`PMSR_WORD_W-1:0] data;
    } pmsr_reply_s;

endpackage : pmsr_pkg

/* src/pmsr_sync2.sv */
// Two-flop synchroniser for asynchronous comparator pins
`timescale 1ns/1ps

module pmsr_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            meta <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule : pmsr_sync2

/* src/pmsr_sticky_flags.sv */
// Group of latched status flags; a set in the clear cycle wins
`timescale 1ns/1ps

module pmsr_sticky_flags #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic clear_in,
    output logic [WIDTH-1:0] flags_out
);

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            flags_out <= '0;
        end else begin
            flags_out <= set_in | (flags_out & {WIDTH{~clear_in}});
        end
    end

endmodule : pmsr_sticky_flags

/* tb/pmsr_status_monitor.sv */
// Concurrent checks on the status register bank ports
`timescale 1ns/1ps

module pmsr_status_monitor
    import pmsr_pkg::*;
#(
    parameter bit HAS_OUTPUT_VOLTAGE_SENSE_PIN_SENSE = 1'b1
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic clear_faults_in,
    input wire pmsr_mon_events_s mon_events_in,
    input wire logic gate_off_in,
    input wire logic [7:0] maker_specific_flags_in,
    input wire logic feedback_sense_pin_in,
    input wire logic input_high_threshold_pin_in,
    input wire logic input_low_threshold_pin_in,
    input wire pmsr_reply_s reply_out,
    input wire logic power_ok_pin_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_reply_one_cycle: assert property (cmd_valid_in |=> reply_out.valid)
        else $error("reply missing one cycle after request");
    a_no_stray_reply: assert property (!cmd_valid_in |=> !reply_out.valid)
        else $error("reply without request");
    a_word_kind: assert property (cmd_valid_in |=>
        reply_out.is_word == ($past(cmd_code_in) == 8'h79))
        else $error("word flag does not match code");
    a_summary_rsvd: assert property (reply_out.valid && reply_out.is_word |->
        reply_out.data[10:8] == 3'h0)
        else $error("summary reserved bits set");
    a_power_bit: assert property (reply_out.valid && reply_out.is_word |->
        reply_out.data[11] == !$past(power_ok_pin_out))
        else $error("summary bit 11 not inverse of power ok");
    a_pending_or: assert property (reply_out.valid && reply_out.is_word |->
        reply_out.data[0] == |reply_out.data[15:12])
        else $error("status bit 0 disagrees with pending bits");
    a_maker_bit: assert property (reply_out.valid && reply_out.is_word |->
        reply_out.data[12] == |$past(maker_specific_flags_in))
        else $error("summary bit 12 wrong");
    a_flag_rsvd: assert property (cmd_valid_in && cmd_code_in inside {8'h7A, 8'h7B} |=>
        (reply_out.data & 16'hFF1F) == 16'h0000 && !reply_out.data[7 - $past(cmd_code_in[0])])
        else $error("reserved flag bits set");
    a_input_rsvd: assert property (cmd_valid_in && cmd_code_in == 8'h7C |=>
        reply_out.data[15:0] == {8'h00, reply_out.data[7:4], 4'h0})
        else $error("input flag low nibble set");
    a_warn_latch: assert property (mon_events_in.current_high_warning ##1
        (cmd_valid_in && cmd_code_in == 8'h7B) |=> reply_out.data[5])
        else $error("current warning not latched");
    a_refused_zero: assert property (cmd_valid_in && !(cmd_code_in inside {[8'h78:8'h7C]})
        |=> reply_out.refused && reply_out.data == 16'h0000)
        else $error("unknown code not refused");
    a_output_voltage_sense_pin_absent: assert property (cmd_valid_in && cmd_code_in == 8'h7A |=>
        reply_out.refused == !HAS_OUTPUT_VOLTAGE_SENSE_PIN_SENSE)
        else $error("voltage flag read refusal wrong for variant");
endmodule : pmsr_status_monitor

bind pmsr_status_regs pmsr_status_monitor #(.HAS_OUTPUT_VOLTAGE_SENSE_PIN_SENSE(HAS_OUTPUT_VOLTAGE_SENSE_PIN_SENSE)) mon_u (.*);

/* tb/pmsr_host_model.sv */
// Host side model that issues status read requests
`timescale 1ns/1ps

module pmsr_host_model (
    output logic cmd_valid_out,
    output logic [7:0] cmd_code_out
);
    initial begin
        cmd_valid_out = 1'h0;
        cmd_code_out = 8'h00;
    end
    task automatic issue(input logic [7:0] c);
        cmd_valid_out = 1'h1;
        cmd_code_out = c;
    endtask : issue
    // Idle code keeps changing so a stale value never looks valid
    task automatic drop();
        cmd_valid_out = 1'h0;
        cmd_code_out = ~cmd_code_out;
    endtask : drop
endmodule : pmsr_host_model

/* tb/tb.sv */
// Self-checking bench for the status register bank
`timescale 1ns/1ps

module tb;
    import pmsr_pkg::*;
    logic ref_clk_in, rst_n_in, clr, gate, fb, hi, lo, cmd_valid, pg_m, ce;
    logic [7:0] cmd_code, maker, vf, cf, inf;
    logic [31:0] seed;
    logic [5:0] rnd_ev;
    logic ce0, power_ok0;
    pmsr_reply_s reply0;
    logic [18:0] exp_q0[$];
    pmsr_mon_events_s mon;
    pmsr_reply_s reply;
    logic power_ok;
    logic [18:0] exp_q[$];
    int mismatches, check_count, cyc;
    logic [7:0] codes[5] = '{8'h7B, 8'h7C, 8'h7A, 8'h79, 8'h78};

    pmsr_status_regs dut_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .clear_faults_in(clr),
        .mon_events_in(mon), .gate_off_in(gate), .maker_specific_flags_in(maker),
        .feedback_sense_pin_in(fb), .input_high_threshold_pin_in(hi),
        .input_low_threshold_pin_in(lo), .reply_out(reply), .power_ok_pin_out(power_ok));
    // Variant without the output voltage sense pin sees the same stimulus
    pmsr_status_regs #(.HAS_OUTPUT_VOLTAGE_SENSE_PIN_SENSE(1'b0)) dut_u_nosense (.ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code),
        .clear_faults_in(clr), .mon_events_in(mon), .gate_off_in(gate),
        .maker_specific_flags_in(maker), .feedback_sense_pin_in(fb),
        .input_high_threshold_pin_in(hi), .input_low_threshold_pin_in(lo),
        .reply_out(reply0), .power_ok_pin_out(power_ok0));
    pmsr_host_model host_u (.cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code));

    initial begin
        ref_clk_in = 1'h0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift

    function automatic logic [18:0] exp_rep(input logic [7:0] c, input bit nv);
        logic [7:0] sb;
        logic [7:0] vx;
        logic [15:0] d;
        logic rf;
        vx = nv ? 8'h00 : vf;
        sb = {1'h0, gate, 1'h0, cf[7], inf[4], 1'h0, nv ? ce0 : ce, |{vx, cf, inf, maker}};
        rf = 1'h0;
        case (c)
            8'h78: d = {8'h00, sb};
            8'h79: d = {|vx, |cf, |inf, |maker, ~pg_m, 3'h0, sb};
            8'h7A: begin
                d = {8'h00, vx};
                rf = nv;
            end
            8'h7B: d = {8'h00, cf};
            8'h7C: d = {8'h00, inf};
            default: begin
                d = 16'h0000;
                rf = 1'h1;
            end
        endcase
        return {1'h1, c == 8'h79, rf, d};
    endfunction : exp_rep

    task automatic chk(input string n, input logic [18:0] e, input logic [18:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    // Every strobe is written once per edge, so back-to-back reads never glitch
    task automatic step(input logic [5:0] ev = 6'h00, input logic cl = 1'h0,
        input logic go = 1'h0, input logic [7:0] code = 8'h00);
        @(posedge ref_clk_in);
        #1;
        mon = pmsr_mon_events_s'(ev);
        clr = cl;
        if (go) host_u.issue(code);
        else host_u.drop();
    endtask : step

    task automatic rd(input logic [7:0] c);
        step(6'h00, 1'h0, 1'h1, c);
        exp_q.push_back(exp_rep(c, 1'b0));
        exp_q0.push_back(exp_rep(c, 1'b1));
        // refused code latches the comm error bit
        if (exp_q[$][16]) ce = 1'h1;
        if (exp_q0[$][16]) ce0 = 1'h1;
    endtask : rd

    task automatic rd_all();
        foreach (codes[i]) rd(codes[i]);
        step();
    endtask : rd_all

    task automatic clear_all();
        step(6'h00, 1'h1);
        {vf, cf, inf, ce, ce0} = '0;
    endtask : clear_all

    always @(negedge ref_clk_in) begin
        if (reply.valid === 1'h1) begin
            if (exp_q.size() == 0) chk("stray reply", 19'h00000, reply);
            else chk("reply", exp_q.pop_front(), reply);
        end
        if (reply0.valid === 1'h1) begin
            if (exp_q0.size() == 0) chk("stray variant reply", 19'h00000, reply0);
            else chk("variant reply", exp_q0.pop_front(), reply0);
        end
    end

    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        {rst_n_in, clr, gate, hi, ce, ce0, maker, vf, cf, inf} = '0;
        {fb, lo, pg_m} = 3'h7;
        mon = pmsr_mon_events_s'(6'h00);
        seed = 32'h0000004D;
        repeat (4) @(posedge ref_clk_in);
        #1;
        rst_n_in = 1'h1;
        rd_all();
        chk("power ok", 19'h1, {18'h0, power_ok});
        chk("variant power ok", 19'h1, {18'h0, power_ok0});
        for (int i = 0; i < 12; i++) begin
            rnd_ev = (i == 0) ? 6'h3F : 6'(xorshift());
            step(rnd_ev);
            maker = seed[8] ? seed[15:8] : 8'h00;
            gate = seed[16];
            vf |= {1'h0, mon.output_high_warning, mon.output_low_warning, 5'h00};
            cf |= {mon.current_timeout_fault, 1'h0, mon.current_high_warning, 5'h00};
            inf |= {2'h0, mon.input_high_warning, mon.input_low_warning, 4'h0} << 1;
            rd_all();
            if (seed[20]) clear_all();
        end
        clear_all();
        step();
        hi = 1'h1;
        lo = 1'h0;
        fb = 1'h0;
        {inf[7], inf[4], pg_m} = 3'h6;
        repeat (4) step();
        rd_all();
        chk("power ok", 19'h0, {18'h0, power_ok});
        chk("variant power ok", 19'h0, {18'h0, power_ok0});
        {hi, lo, fb} = 3'h3;
        repeat (4) step();
        pg_m = 1'h1;
        rd_all();
        clear_all();
        rd(8'h00);
        rd(8'hFF);
        rd_all();
        clear_all();
        rd_all();
        repeat (3) step();
        chk("queue left", 19'h0, 19'(exp_q.size() + exp_q0.size()));
        finish_test();
    end
endmodule : tb
